// *** src/bds_params.svh ***
// Offsets, field positions, reset values and timing counts
`ifndef BDS_PARAMS_SVH
`define BDS_PARAMS_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define BDS_OFF_CFG 8'h00
`define BDS_OFF_DELAY 8'h04
`define BDS_OFF_RELAY1 8'h08
`define BDS_OFF_QTY 8'h0C
`define BDS_OFF_CMD 8'h10
`define BDS_OFF_TEST 8'h14
`define BDS_OFF_STATUS 8'h18
`define BDS_OFF_DELIV 8'h1C
`define BDS_OFF_JET 8'h20
`define BDS_OFF_TOTAL 8'h24
`define BDS_OFF_DAILY 8'h28
`define BDS_OFF_RATE 8'h2C
`define BDS_OFF_KFACT 8'h30
`define BDS_OFF_EXTRD 8'h34
`define BDS_OFF_PULSE 8'h38
`define BDS_OFF_STORE 8'h40
// ----------------------------------------
// Field positions
// ----------------------------------------
`define BDS_CFG_JET 0
`define BDS_CFG_ALIN 1
`define BDS_CFG_ALPOST 2
`define BDS_CFG_INV1 3
`define BDS_CFG_INV2 4
`define BDS_CFG_FUNC 6:5
`define BDS_CFG_OPT 10:8
`define BDS_CMD_START 0
`define BDS_CMD_MEM 1
`define BDS_CMD_RESUME 2
`define BDS_CMD_CANCEL 3
`define BDS_CMD_TOTCLR 4
`define BDS_CMD_ACK 5
`define BDS_CMD_FREQ 6
`define BDS_CMD_SLOT 10:8
// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define BDS_RST_CFG 32'h0000_0247
`define BDS_RST_DELAY 32'h0064_0064
`define BDS_RST_RELAY1 32'h0064_0000
`define BDS_RST_KFACT 32'h0000_0064
`define BDS_FULL_PCT 7'h64
`define BDS_QTY_MAX 17'h186A0
`define BDS_PULSE_MAX_S 10'h12C
`define BDS_SEC_NS 1000000000
`define BDS_CLK_NS 4
`endif

// *** src/bds_pkg.sv ***
// Types for the batch dose supervisor
package bds_pkg;
  typedef enum logic [2:0] {
    BDS_LOCAL_MEMORY_OPTION, BDS_LOCAL_MANUAL_OPTION, BDS_MEMORY_PLUS_MANUAL_OPTION, BDS_EXTERNAL_MEMORY_OPTION, BDS_PULSE
  } bds_option_t;
  typedef enum logic [1:0] {
    BDS_R2_ALARM, BDS_R2_END, BDS_R2_VALVE
  } bds_r2_func_t;
  typedef enum logic [1:0] {
    BDS_IDLE, BDS_DOSE, BDS_POST, BDS_HALT
  } bds_state_t;
endpackage

// *** src/bds_sec_timer.sv ***
// Whole-second delay timer that restarts when its condition drops
`timescale 1ns/1ns
`default_nettype none
module bds_sec_timer (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic tick,
  input wire logic cond,
  input wire logic [9:0] delay,
  output logic done
);
  logic [9:0] secs;

  // ----------------------------------------
  // Second counter
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      secs <= 10'h000;
    end else if (!cond) begin
      secs <= 10'h000;
    end else if (tick && secs != 10'h3FF) begin
      secs <= secs + 10'h001;
    end
  end

  assign done = cond && (secs >= delay);
endmodule
`default_nettype wire

// *** src/bds_pulse_check.sv ***
// Pulse-duration quantity and error check for the pulse option
`timescale 1ns/1ns
`default_nettype none
`include "bds_params.svh"
module bds_pulse_check (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic tick,
  input wire logic enable,
  input wire logic pulse,
  input wire logic [16:0] rate,
  input wire logic [16:0] delivered,
  output logic [16:0] requested,
  output logic [9:0] secs,
  output logic error
);
  logic [33:0] prod;

  assign prod = 34'(secs) * 34'(rate);

  // ----------------------------------------
  // Duration and requested quantity
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      secs <= 10'h000;
      requested <= 17'h00000;
    end else if (!enable) begin
      secs <= 10'h000;
      requested <= 17'h00000;
    end else if (pulse && tick && secs != 10'h3FF) begin
      secs <= secs + 10'h001;
      requested <= (prod + 34'(rate) > 34'(`BDS_QTY_MAX)) ?
        `BDS_QTY_MAX : 17'(prod + 34'(rate));
    end
  end

  // ----------------------------------------
  // Error conditions
  // ----------------------------------------
  assign error = enable && (
    (pulse && secs > `BDS_PULSE_MAX_S) ||
    (pulse && requested != 17'h00000 && delivered >= requested) ||
    (prod + 34'(rate) > 34'(`BDS_QTY_MAX) && pulse) ||
    (pulse && delivered >= `BDS_QTY_MAX));
endmodule
`default_nettype wire

// *** src/bds_top.sv ***
// Batch dose supervisor: valves, alarms, totals, AHB-Lite registers
//
// Notes on behaviour
// - With jet correction on, after-close flow is stored and subtracted next dose.
// - In-dose and after-dose alarms enable separately, each with own delay.
// - Alarm delays take whole seconds from 0 to 999.
// - Alarm drives the open-collector output, and relay 2 in alarm function.
// - Relay 1 drives only the main valve, with delay and inversion.
// - Main valve delivers a set percentage; relay 2 aux valve gives the rest.
// - Relay 2 serves alarm, end-of-dose or aux valve; always invertible.
// - Percentage other than 100 forces relay 2 to valve control.
// - Relay 1 keeps the main valve shut until its delay elapses.
// - Totals clear command zeroes main and daily totals together.
// - Test mode lets software energise each relay directly.
// - In test mode, frequency readout confirm energises relay 1, opening the main valve.
// - Alarm if a valve is open with no flow for the in-dose delay.
// - Alarm if flow continues after close beyond the after-dose delay.
// - An alarmed dose waits for resume or cancel, keypad or binary inputs.
// - Pulse error if pulse exceeds 300 s or the dose time needed.
// - Pulse error if request exceeds 100000 or delivery hits it mid-pulse.
// - Corrupt parameters raise an error held until acknowledged; defaults are loaded while the corrupt input is high.
// - Defaults: K 1.00, memory-plus-manual, jet on, alarms 100 s, 100 %.
// - External test readout shows coded stored quantity, dash flag when zero.
// - Manual dose must exceed 0.2 times K; zero entry starts nothing.
//
// The register addresses and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "bds_params.svh"
module bds_top
  import bds_pkg::*;
#(
  parameter int SEC_CYCLES = `BDS_SEC_NS / `BDS_CLK_NS
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic flow_pulse,
  input wire logic [4:0] bin_in,
  input wire logic param_corrupt,
  input wire logic alarm_oc_i,
  output logic alarm_oc_o,
  output logic alarm_oc_oe_n,
  output logic relay1_out,
  output logic relay2_out
);
  logic [31:0] cfg, dly, rly1, qty_reg, test, rate, kfact;
  logic [16:0] store [0:6];
  logic [16:0] delivered, jet, target, main_thr;
  logic [31:0] total, daily;
  bds_state_t state;
  logic [1:0] s_flow, s_corr, s_oc;
  logic [4:0] s_bin0, s_bin;
  logic flow_d, bin3_d, tick, flow_seen, flow_prev, flow;
  logic [27:0] presc;
  logic alarm, param_err, reject, end_flag, freq_open;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic [16:0] slot_qty, ext_qty;
  logic main_open, aux_open, in_done, post_done, r1_done;
  logic pulse_err;
  logic [16:0] pulse_req;
  logic [9:0] pulse_secs;
  logic [1:0] r2_func;
  logic r1_drive, r2_drive;
  logic wr_cmd, do_start, do_resume, do_cancel, ext_start;
  logic [16:0] start_qty;
  logic flow_edge;

  function automatic logic [16:0] pct_of(input logic [16:0] q,
                                         input logic [6:0] p);
    logic [23:0] m;
    m = 24'(q) * 24'(p);
    pct_of = 17'(m / 24'h64);
  endfunction

  function automatic logic qty_ok(input logic [16:0] q,
                                  input logic [31:0] k);
    qty_ok = (36'(q) * 36'h1F4) > 36'(k);
  endfunction

  // ----------------------------------------
  // Input synchronisers and one-second tick
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_flow <= 2'h0;
      s_corr <= 2'h0;
      s_oc <= 2'h0;
      s_bin0 <= 5'h00;
      s_bin <= 5'h00;
      flow_d <= 1'b0;
      bin3_d <= 1'b0;
    end else begin
      s_flow <= {s_flow[0], flow_pulse};
      s_corr <= {s_corr[0], param_corrupt};
      s_oc <= {s_oc[0], alarm_oc_i};
      s_bin0 <= bin_in;
      s_bin <= s_bin0;
      flow_d <= s_flow[1];
      bin3_d <= s_bin[3];
    end
  end

  assign flow_edge = s_flow[1] && !flow_d;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      presc <= 28'h0000000;
      tick <= 1'b0;
    end else if (presc >= 28'(SEC_CYCLES - 1)) begin
      presc <= 28'h0000000;
      tick <= 1'b1;
    end else begin
      presc <= presc + 28'h0000001;
      tick <= 1'b0;
    end
  end

  // Flow is present if a pulse arrived this second or the last
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flow_seen <= 1'b0;
      flow_prev <= 1'b0;
    end else if (tick) begin
      flow_prev <= flow_seen || flow_edge;
      flow_seen <= 1'b0;
    end else if (flow_edge) begin
      flow_seen <= 1'b1;
    end
  end

  assign flow = flow_seen || flow_prev;

  // ----------------------------------------
  // AHB-Lite slave
  // ----------------------------------------
  assign wr_cmd = wr_pend && wr_addr == `BDS_OFF_CMD;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (hready) begin
      wr_pend <= hsel && htrans[1] && hwrite;
      wr_addr <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      unique case (haddr[7:0])
        `BDS_OFF_CFG: hrdata <= cfg;
        `BDS_OFF_DELAY: hrdata <= dly;
        `BDS_OFF_RELAY1: hrdata <= rly1;
        `BDS_OFF_QTY: hrdata <= qty_reg;
        `BDS_OFF_TEST: hrdata <= test;
        `BDS_OFF_STATUS: hrdata <= {20'h00000, s_oc[1], freq_open,
          relay2_out, relay1_out, end_flag, reject, param_err,
          pulse_err, alarm, flow, 2'(state)};
        `BDS_OFF_DELIV: hrdata <= 32'(delivered);
        `BDS_OFF_JET: hrdata <= 32'(jet);
        `BDS_OFF_TOTAL: hrdata <= total;
        `BDS_OFF_DAILY: hrdata <= daily;
        `BDS_OFF_RATE: hrdata <= rate;
        `BDS_OFF_KFACT: hrdata <= kfact;
        `BDS_OFF_EXTRD: hrdata <= {14'h0000, ext_qty == 17'h00000,
          ext_qty};
        `BDS_OFF_PULSE: hrdata <= {5'h00, pulse_secs, pulse_req};
        default: hrdata <= (haddr[7:0] >= `BDS_OFF_STORE &&
          haddr[7:0] < `BDS_OFF_STORE + 8'h1C) ?
          32'(store[3'(haddr[4:2])]) : 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg <= `BDS_RST_CFG;
      dly <= `BDS_RST_DELAY;
      rly1 <= `BDS_RST_RELAY1;
      kfact <= `BDS_RST_KFACT;
      qty_reg <= 32'h0000_0000;
      rate <= 32'h0000_0000;
      test <= 32'h0000_0000;
      for (int i = 0; i < 7; i++) begin
        store[i] <= 17'h00000;
      end
    end else if (s_corr[1]) begin
      cfg <= `BDS_RST_CFG;
      dly <= `BDS_RST_DELAY;
      rly1 <= `BDS_RST_RELAY1;
      kfact <= `BDS_RST_KFACT;
      for (int i = 0; i < 7; i++) begin
        store[i] <= 17'h00000;
      end
    end else if (wr_pend) begin
      unique case (wr_addr)
        `BDS_OFF_CFG: cfg <= {21'h000000, hwdata[10:8], 1'b0,
          hwdata[6:0]};
        `BDS_OFF_DELAY: dly <= {6'h00, (hwdata[25:16] > 10'h3E7) ?
          10'h3E7 : hwdata[25:16], 6'h00, (hwdata[9:0] > 10'h3E7) ?
          10'h3E7 : hwdata[9:0]};
        `BDS_OFF_RELAY1: rly1 <= {9'h000, (hwdata[22:16] >
          `BDS_FULL_PCT) ? `BDS_FULL_PCT : hwdata[22:16], 6'h00,
          hwdata[9:0]};
        `BDS_OFF_QTY: qty_reg <= {15'h0000, hwdata[16:0]};
        `BDS_OFF_TEST: test <= {29'h00000000, hwdata[2:0]};
        `BDS_OFF_RATE: rate <= {15'h0000, hwdata[16:0]};
        `BDS_OFF_KFACT: kfact <= {15'h0000, hwdata[16:0]};
        default: begin
          if (wr_addr >= `BDS_OFF_STORE &&
              wr_addr < `BDS_OFF_STORE + 8'h1C) begin
            store[3'(wr_addr[4:2])] <= hwdata[16:0];
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Dose start decode
  // ----------------------------------------
  assign slot_qty = store[3'(hwdata[`BDS_CMD_SLOT]) % 3'h7];
  assign ext_qty = (s_bin[2:0] == 3'h0) ? 17'h00000 :
    store[s_bin[2:0] - 3'h1];
  assign ext_start = cfg[`BDS_CFG_OPT] == BDS_EXTERNAL_MEMORY_OPTION && s_bin[3] &&
    !bin3_d;

  always_comb begin
    do_start = 1'b0;
    start_qty = 17'h00000;
    if (wr_cmd && hwdata[`BDS_CMD_START] &&
        (cfg[`BDS_CFG_OPT] == BDS_LOCAL_MANUAL_OPTION ||
         cfg[`BDS_CFG_OPT] == BDS_MEMORY_PLUS_MANUAL_OPTION)) begin
      start_qty = qty_reg[16:0];
      do_start = qty_ok(qty_reg[16:0], kfact);
    end else if (wr_cmd && hwdata[`BDS_CMD_MEM] &&
        (cfg[`BDS_CFG_OPT] == BDS_LOCAL_MEMORY_OPTION ||
         cfg[`BDS_CFG_OPT] == BDS_MEMORY_PLUS_MANUAL_OPTION)) begin
      start_qty = slot_qty;
      do_start = slot_qty != 17'h00000;
    end else if (ext_start) begin
      start_qty = ext_qty;
      do_start = ext_qty != 17'h00000;
    end
  end

  // Binary resume and cancel only count in the external memory option
  assign do_resume = (wr_cmd && hwdata[`BDS_CMD_RESUME]) ||
    (cfg[`BDS_CFG_OPT] == BDS_EXTERNAL_MEMORY_OPTION && ext_start);
  assign do_cancel = (wr_cmd && hwdata[`BDS_CMD_CANCEL]) ||
    (cfg[`BDS_CFG_OPT] == BDS_EXTERNAL_MEMORY_OPTION && s_bin[4]);

  // ----------------------------------------
  // Timers and pulse option check
  // ----------------------------------------
  bds_sec_timer u_in_timer (
    .hclk(hclk), .hresetn(hresetn), .tick(tick),
    .cond(state == BDS_DOSE && (main_open || aux_open) && !flow &&
          cfg[`BDS_CFG_ALIN]),
    .delay(dly[9:0]), .done(in_done));
  bds_sec_timer u_post_timer (
    .hclk(hclk), .hresetn(hresetn), .tick(tick),
    .cond(state == BDS_POST && flow && cfg[`BDS_CFG_ALPOST]),
    .delay(dly[25:16]), .done(post_done));
  bds_sec_timer u_r1_timer (
    .hclk(hclk), .hresetn(hresetn), .tick(tick),
    .cond(state == BDS_DOSE),
    .delay(rly1[9:0]), .done(r1_done));
  bds_pulse_check u_pulse (
    .hclk(hclk), .hresetn(hresetn), .tick(tick),
    .enable(cfg[`BDS_CFG_OPT] == BDS_PULSE && state != BDS_IDLE),
    .pulse(s_bin[0]), .rate(rate[16:0]), .delivered(delivered),
    .requested(pulse_req), .secs(pulse_secs), .error(pulse_err));

  // ----------------------------------------
  // Dose sequence
  // ----------------------------------------
  assign main_thr = pct_of(target, rly1[22:16]);
  assign main_open = state == BDS_DOSE && delivered < main_thr &&
    r1_done;
  assign aux_open = state == BDS_DOSE && delivered >= main_thr &&
    delivered < target;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= BDS_IDLE;
      delivered <= 17'h00000;
      target <= 17'h00000;
      jet <= 17'h00000;
      alarm <= 1'b0;
      end_flag <= 1'b0;
      reject <= 1'b0;
    end else begin
      unique case (state)
        BDS_IDLE: begin
          if (s_bin[0] && cfg[`BDS_CFG_OPT] == BDS_PULSE && !param_err) begin
            state <= BDS_DOSE;
            delivered <= 17'h00000;
            target <= 17'h00001;
            end_flag <= 1'b0;
          end else if (do_start && !param_err) begin
            state <= BDS_DOSE;
            delivered <= 17'h00000;
            target <= (cfg[`BDS_CFG_JET] && start_qty > jet) ?
              start_qty - jet : start_qty;
            end_flag <= 1'b0;
            reject <= 1'b0;
          end else if (wr_cmd && hwdata[`BDS_CMD_START] &&
                       qty_reg[16:0] != 17'h00000) begin
            reject <= 1'b1;
          end
        end
        BDS_DOSE: begin
          if (flow_edge) begin
            delivered <= delivered + 17'h00001;
          end
          if (cfg[`BDS_CFG_OPT] == BDS_PULSE) begin
            target <= (pulse_req > jet && cfg[`BDS_CFG_JET]) ?
              pulse_req - jet : pulse_req;
          end
          if (in_done || pulse_err) begin
            state <= BDS_HALT;
            alarm <= in_done;
          end else if (do_cancel) begin
            state <= BDS_IDLE;
          end else if (delivered >= target && target != 17'h00000 &&
                       !(cfg[`BDS_CFG_OPT] == BDS_PULSE && s_bin[0])) begin
            state <= BDS_POST;
            jet <= 17'h00000;
          end
        end
        BDS_POST: begin
          if (flow_edge && cfg[`BDS_CFG_JET]) begin
            jet <= jet + 17'h00001;
          end
          if (post_done) begin
            state <= BDS_HALT;
            alarm <= 1'b1;
          end else if (tick && !flow_seen && !flow_edge) begin
            state <= BDS_IDLE;
            end_flag <= 1'b1;
          end
        end
        BDS_HALT: begin
          if (do_cancel) begin
            state <= BDS_IDLE;
            alarm <= 1'b0;
          end else if (do_resume) begin
            state <= (delivered < target) ? BDS_DOSE : BDS_IDLE;
            alarm <= 1'b0;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Totals, parameter error, test latch
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      total <= 32'h0000_0000;
      daily <= 32'h0000_0000;
    end else if (wr_cmd && hwdata[`BDS_CMD_TOTCLR]) begin
      total <= 32'h0000_0000;
      daily <= 32'h0000_0000;
    end else if (flow_edge) begin
      total <= total + 32'h0000_0001;
      daily <= daily + 32'h0000_0001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      param_err <= 1'b0;
    end else if (s_corr[1]) begin
      param_err <= 1'b1;
    end else if (wr_cmd && hwdata[`BDS_CMD_ACK]) begin
      param_err <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      freq_open <= 1'b0;
    end else if (!test[0]) begin
      freq_open <= 1'b0;
    end else if (wr_cmd && hwdata[`BDS_CMD_FREQ]) begin
      freq_open <= 1'b1;
    end
  end

  // ----------------------------------------
  // Relay and alarm outputs
  // ----------------------------------------
  assign r2_func = (rly1[22:16] != `BDS_FULL_PCT) ? 2'(BDS_R2_VALVE) :
    cfg[`BDS_CFG_FUNC];

  always_comb begin
    if (test[0]) begin
      r1_drive = test[1] || freq_open;
      r2_drive = test[2];
    end else begin
      r1_drive = main_open;
      unique case (r2_func)
        2'(BDS_R2_ALARM): r2_drive = alarm;
        2'(BDS_R2_END): r2_drive = end_flag;
        default: r2_drive = aux_open;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      relay1_out <= 1'b0;
      relay2_out <= 1'b0;
      alarm_oc_o <= 1'b0;
      alarm_oc_oe_n <= 1'b1;
    end else begin
      relay1_out <= r1_drive ^ cfg[`BDS_CFG_INV1];
      relay2_out <= r2_drive ^ cfg[`BDS_CFG_INV2];
      alarm_oc_o <= 1'b0;
      alarm_oc_oe_n <= !alarm;
    end
  end
endmodule
`default_nettype wire

// *** bench/bds_monitor.sv ***
// Checker of bus and pin relations for the dose supervisor
`timescale 1ns/1ns
`default_nettype none
`include "bds_params.svh"
module bds_monitor (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic alarm_oc_o,
  input wire logic relay1_out
);
  // --
  // Checks
  // --
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  logic rd;
  logic [7:0] ra;
  assign rd = hsel && hready && htrans[1] && !hwrite;
  assign ra = haddr[7:0];
  a_oc_low: assert property (!alarm_oc_o)
    else $error("oc data high");
  a_rdata_hold: assert property (!rd |=> $stable(hrdata))
    else $error("read data moved");
  a_cmd_zero: assert property (rd && ra == `BDS_OFF_CMD |=> hrdata == 32'h0)
    else $error("cmd read not zero");
  a_delay_clamp: assert property (rd && ra == `BDS_OFF_DELAY
    |=> hrdata[9:0] <= 10'h3E7 && hrdata[25:16] <= 10'h3E7)
    else $error("delay over limit");
  a_pct_clamp: assert property (rd && ra == `BDS_OFF_RELAY1
    |=> hrdata[22:16] <= `BDS_FULL_PCT)
    else $error("percent over limit");
  a_dash_flag: assert property (rd && ra == `BDS_OFF_EXTRD
    |=> hrdata[17] == (hrdata[16:0] == 17'h0))
    else $error("dash flag wrong");
  a_pulse_cap: assert property (rd && ra == `BDS_OFF_PULSE
    |=> hrdata[16:0] <= `BDS_QTY_MAX)
    else $error("request over limit");
  a_relay1_shown: assert property (rd && ra == `BDS_OFF_STATUS
    |=> hrdata[8] == $past(relay1_out))
    else $error("relay status wrong");
endmodule
bind bds_top bds_monitor bds_monitor_inst (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hrdata(hrdata), .alarm_oc_o(alarm_oc_o),
  .relay1_out(relay1_out));
`default_nettype wire

// *** bench/bds_flow_model.sv ***
// Valve and flow sensor model facing the dose supervisor
`timescale 1ns/1ns
`default_nettype none
module bds_flow_model (
  input wire logic hclk,
  input wire logic valve_main,
  input wire logic valve_aux,
  input wire logic dry,
  output logic flow_pulse
);
  // --
  // Flow source
  // --
  logic [2:0] phase;
  initial phase = 3'h0;
  initial flow_pulse = 1'b0;
  always @(posedge hclk) begin
    phase <= phase + 3'h1;
    flow_pulse <= !dry && phase[2] && (valve_main || valve_aux);
  end
endmodule
`default_nettype wire

// *** bench/tb_bds_top.sv ***
// Register-level bench for the batch dose supervisor
`timescale 1ns/1ns
`default_nettype none
`include "bds_params.svh"
module tb_bds_top;
  // --
  // Bench
  // --
  logic hclk, hresetn, hsel, hwrite, flow_pulse, param_corrupt, dry;
  logic hready, hresp, oc_o, oc_oe_n, relay1_out, relay2_out;
  logic [31:0] haddr, hwdata, hrdata, rd_val;
  logic [1:0] htrans;
  logic [4:0] bin_in;
  int n_mismatch, cmp_count;
  bds_top #(.SEC_CYCLES(20)) bds_top_inst (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hrdata(hrdata), .hresp(hresp), .flow_pulse(flow_pulse),
    .bin_in(bin_in), .param_corrupt(param_corrupt),
    .alarm_oc_i(oc_oe_n ? 1'b1 : oc_o), .alarm_oc_o(oc_o),
    .alarm_oc_oe_n(oc_oe_n), .relay1_out(relay1_out),
    .relay2_out(relay2_out));
  bds_flow_model bds_flow_model_inst (.hclk(hclk), .valve_main(relay1_out),
    .valve_aux(relay2_out), .dry(dry), .flow_pulse(flow_pulse));
  always #2 hclk = ~hclk;
  task automatic wait_rdy;
    do begin
      @(posedge hclk);
    end while (hready !== 1'b1);
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    rd_val = hrdata;
  endtask
  task automatic cmp(input string nm, input logic [31:0] exp, got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0);
    cmp($sformatf("register %h", a), exp, rd_val);
  endtask
  task automatic poll(input logic [31:0] m, v);
    int t;
    t = 0;
    do begin
      bus(`BDS_OFF_STATUS, 1'b0, 32'h0);
      t++;
    end while ((rd_val & m) !== v && t < 500);
    cmp("status", v, rd_val & m);
  endtask
  task automatic final_report;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #100000;
    n_mismatch++;
    final_report;
  end
  initial begin
    {hclk, hresetn, hsel, hwrite, param_corrupt, dry} = 6'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    bin_in = 5'h0;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk(`BDS_OFF_CFG, `BDS_RST_CFG);
    chk(`BDS_OFF_DELAY, `BDS_RST_DELAY);
    chk(`BDS_OFF_RELAY1, `BDS_RST_RELAY1);
    chk(`BDS_OFF_KFACT, `BDS_RST_KFACT);
    chk(`BDS_OFF_STORE + 8'h18, 32'h0);
    chk(`BDS_OFF_PULSE, 32'h0);
    chk(`BDS_OFF_CMD, 32'h0);
    cmp("hresp", 32'h0, {31'h0, hresp});
    bus(`BDS_OFF_DELAY, 1'b1, 32'h03FF_0002);
    chk(`BDS_OFF_DELAY, 32'h03E7_0002);
    bus(`BDS_OFF_TEST, 1'b1, 32'h7);
    repeat (3) @(posedge hclk);
    cmp("relays", 32'h3, {30'h0, relay1_out, relay2_out});
    bus(`BDS_OFF_CFG, 1'b1, 32'h21F);
    bus(`BDS_OFF_TEST, 1'b1, 32'h1);
    repeat (3) @(posedge hclk);
    cmp("inverted", 32'h3, {30'h0, relay1_out, relay2_out});
    bus(`BDS_OFF_CFG, 1'b1, `BDS_RST_CFG);
    bus(`BDS_OFF_CMD, 1'b1, 32'h40);
    poll(32'h500, 32'h500);
    bus(`BDS_OFF_TEST, 1'b1, 32'h0);
    bus(`BDS_OFF_RELAY1, 1'b1, 32'h0064_0002);
    bus(`BDS_OFF_QTY, 1'b1, 32'h14);
    bus(`BDS_OFF_CMD, 1'b1, 32'h1);
    repeat (15) @(posedge hclk);
    cmp("main held", 32'h0, {31'h0, relay1_out});
    repeat (60) @(posedge hclk);
    cmp("main open", 32'h1, {31'h0, relay1_out});
    poll(32'h83, 32'h80);
    bus(`BDS_OFF_TOTAL, 1'b0, 32'h0);
    cmp("total", 32'h1, {31'h0, rd_val != 32'h0});
    bus(`BDS_OFF_CMD, 1'b1, 32'h10);
    chk(`BDS_OFF_TOTAL, 32'h0);
    chk(`BDS_OFF_DAILY, 32'h0);
    dry <= 1'b1;
    bus(`BDS_OFF_CMD, 1'b1, 32'h1);
    poll(32'h0B, 32'h0B);
    cmp("alarm pin", 32'h0, {31'h0, oc_oe_n});
    bus(`BDS_OFF_CMD, 1'b1, 32'h8);
    poll(32'h3, 32'h0);
    dry <= 1'b0;
    bus(`BDS_OFF_CFG, 1'b1, 32'h207);
    bus(`BDS_OFF_RELAY1, 1'b1, 32'h0032_0000);
    bus(`BDS_OFF_QTY, 1'b1, 32'h10);
    bus(`BDS_OFF_CMD, 1'b1, 32'h1);
    poll(32'h203, 32'h201);
    poll(32'h83, 32'h80);
    bus(`BDS_OFF_KFACT, 1'b1, 32'h3E8);
    bus(`BDS_OFF_QTY, 1'b1, 32'h2);
    bus(`BDS_OFF_CMD, 1'b1, 32'h1);
    poll(32'h43, 32'h40);
    bus(`BDS_OFF_STORE, 1'b1, 32'h5);
    bin_in <= 5'h1;
    repeat (4) @(posedge hclk);
    chk(`BDS_OFF_EXTRD, 32'h5);
    bin_in <= 5'h2;
    repeat (4) @(posedge hclk);
    chk(`BDS_OFF_EXTRD, 32'h0002_0000);
    param_corrupt <= 1'b1;
    bus(`BDS_OFF_CFG, 1'b1, 32'h0);
    repeat (4) @(posedge hclk);
    chk(`BDS_OFF_CFG, `BDS_RST_CFG);
    poll(32'h20, 32'h20);
    param_corrupt <= 1'b0;
    repeat (4) @(posedge hclk);
    bus(`BDS_OFF_CMD, 1'b1, 32'h20);
    poll(32'h20, 32'h0);
    final_report;
  end
endmodule
`default_nettype wire
